// ### rtl/flash_host_ctrl.sv
// Host-side bus controller that drives a 16-bit asynchronous boot-block flash.
// Assumes one request at a time on the user port; the flash sits on the pins.
`default_nettype none
module flash_host_ctrl #(
   parameter int ADDR_W = 19,
   parameter int DATA_W = 16
) (
   input  wire logic              core_clk_i,
   input  wire logic              resetn_i,
   input  wire logic              req_valid_i,
   input  wire logic [2:0]        req_op_i,
   input  wire logic [ADDR_W-1:0] req_addr_i,
   input  wire logic [DATA_W-1:0] req_data_i,
   input  wire logic              boot_unlock_i,
   output logic                   req_ready_o,
   output logic                   rsp_valid_o,
   output logic [DATA_W-1:0]      rsp_data_o,
   output logic                   rsp_refused_o,
   output logic                   chip_select_n_o,
   output logic                   output_gate_n_o,
   output logic                   write_strobe_n_o,
   output logic                   reset_powerdown_n_o,
   output logic                   boot_lock_n_o,
   output logic [ADDR_W-1:0]      addr_o,
   output logic [DATA_W-1:0]      data_lines_o,
   output logic                   data_lines_oe_o,
   input  wire logic [DATA_W-1:0] data_lines_i
);
   typedef enum logic [3:0] {
      ST_RESET, ST_WAKE, ST_IDLE, ST_READ, ST_WSETUP, ST_WSTROBE, ST_WHOLD,
      ST_RECOVER, ST_PDOWN, ST_ASLEEP
   } state_t;

   state_t                         state;
   logic [flash_host_pkg::CNT_W-1:0] count;
   logic                           second_pending;
   logic [ADDR_W-1:0]              hold_addr;
   logic [DATA_W-1:0]              second_data;
   logic [DATA_W-1:0]              read_data;
   logic                           wake_read_ok;

   // ****************************************
   // Pin input synchroniser
   // ****************************************
   flash_pin_sync #(.WIDTH(DATA_W)) u_sync (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .async_i    (data_lines_i),
      .stable_o   (read_data)
   );

   // Commands outside the defined set are refused at the port.
   function automatic logic cmd_defined(input logic [DATA_W-1:0] c);
      return c == flash_host_pkg::CMD_READ_ARRAY || c == flash_host_pkg::CMD_READ_ID ||
             c == flash_host_pkg::CMD_READ_STATUS || c == flash_host_pkg::CMD_CLEAR_STATUS ||
             c == flash_host_pkg::CMD_SUSPEND || c == flash_host_pkg::CMD_CONFIRM;
   endfunction

   // Boot-block writes without unlock are refused early so no cycle is wasted.
   function automatic logic in_boot(input logic [ADDR_W-1:0] a);
      return a >= flash_host_pkg::BOOT_BASE;
   endfunction

   // ****************************************
   // Sequencer
   // ****************************************
   // One pin phase per state; the counter times each multi-cycle phase in whole cycles.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state          <= ST_RESET;
         count          <= '0;
         second_pending <= 1'b0;
         hold_addr      <= '0;
         second_data    <= '0;
         wake_read_ok   <= 1'b0;
      end else begin
         unique case (state)
            ST_RESET: begin
               // Reset pin stays low long enough to reach deep power-down.
               if (count == flash_host_pkg::CNT_W'(flash_host_pkg::RESET_PULSE_CYC - 1)) begin
                  state <= ST_WAKE;
                  count <= '0;
               end else begin
                  count <= count + 1'b1;
               end
            end
            ST_WAKE: begin
               // No command before the wake-to-write delay has passed.
               if (count == flash_host_pkg::CNT_W'(flash_host_pkg::WAKE_OUT_CYC - 1)) begin
                  wake_read_ok <= 1'b1;
               end
               if (count == flash_host_pkg::CNT_W'(flash_host_pkg::WAKE_WRITE_CYC - 1)) begin
                  state <= ST_IDLE;
                  count <= '0;
               end else begin
                  count <= count + 1'b1;
               end
            end
            ST_IDLE: begin
               count <= '0;
               if (req_valid_i) begin
                  hold_addr      <= req_addr_i;
                  second_pending <= 1'b0;
                  unique case (req_op_i)
                     flash_host_pkg::OP_READ: state <= ST_READ;
                     flash_host_pkg::OP_CMD: begin
                        if (cmd_defined(req_data_i)) state <= ST_WSETUP;
                     end
                     flash_host_pkg::OP_ERASE, flash_host_pkg::OP_PROGRAM: begin
                        if (!in_boot(req_addr_i) || boot_unlock_i) begin
                           state          <= ST_WSETUP;
                           second_pending <= 1'b1;
                           second_data    <= (req_op_i == flash_host_pkg::OP_ERASE)
                                             ? flash_host_pkg::CMD_CONFIRM : req_data_i;
                        end
                     end
                     flash_host_pkg::OP_POWERDOWN: state <= ST_PDOWN;
                     default: ;
                  endcase
               end
            end
            ST_READ: begin
               // Wait access time plus synchroniser latency before sampling.
               if (count == flash_host_pkg::CNT_W'(flash_host_pkg::ACCESS_CYC + 3)) begin
                  state <= ST_RECOVER;
                  count <= '0;
               end else begin
                  count <= count + 1'b1;
               end
            end
            ST_WSETUP: begin
               state <= ST_WSTROBE;
               count <= '0;
            end
            ST_WSTROBE: begin
               if (count == flash_host_pkg::CNT_W'(flash_host_pkg::STROBE_CYC - 1)) begin
                  state <= ST_WHOLD;
                  count <= '0;
               end else begin
                  count <= count + 1'b1;
               end
            end
            ST_WHOLD: begin
               // Data stays driven one cycle after the strobe rises.
               if (second_pending) begin
                  second_pending <= 1'b0;
                  state          <= ST_WSETUP;
               end else begin
                  state <= ST_RECOVER;
               end
            end
            ST_RECOVER: begin
               if (count == flash_host_pkg::CNT_W'(flash_host_pkg::RECOVER_CYC - 1)) begin
                  state <= ST_IDLE;
                  count <= '0;
               end else begin
                  count <= count + 1'b1;
               end
            end
            ST_PDOWN: begin
               if (count == flash_host_pkg::CNT_W'(flash_host_pkg::RESET_PULSE_CYC - 1)) begin
                  state <= ST_ASLEEP;
               end else begin
                  count <= count + 1'b1;
               end
            end
            ST_ASLEEP: begin
               count <= '0;
               if (req_valid_i && req_op_i == flash_host_pkg::OP_WAKE) begin
                  state        <= ST_WAKE;
                  wake_read_ok <= 1'b0;
               end
            end
            default: state <= ST_RESET;
         endcase
      end
   end

   // ****************************************
   // Pin drivers
   // ****************************************
   // Gate and strobe are never low together; no state drives both of them low.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         chip_select_n_o     <= 1'b1;
         output_gate_n_o     <= 1'b1;
         write_strobe_n_o    <= 1'b1;
         reset_powerdown_n_o <= 1'b0;
         data_lines_oe_o     <= 1'b0;
         addr_o              <= '0;
         data_lines_o        <= '0;
      end else begin
         chip_select_n_o     <= !(state == ST_READ || state == ST_WSETUP ||
                                  state == ST_WSTROBE || state == ST_WHOLD);
         output_gate_n_o     <= (state != ST_READ);
         write_strobe_n_o    <= (state != ST_WSTROBE);
         reset_powerdown_n_o <= !(state == ST_RESET || state == ST_PDOWN ||
                                  state == ST_ASLEEP);
         data_lines_oe_o     <= (state == ST_WSETUP || state == ST_WSTROBE ||
                                 state == ST_WHOLD);
         addr_o              <= hold_addr;
         if (state == ST_IDLE && req_valid_i) begin
            data_lines_o <= (req_op_i == flash_host_pkg::OP_ERASE)
                            ? flash_host_pkg::CMD_ERASE_SETUP
                            : (req_op_i == flash_host_pkg::OP_PROGRAM)
                            ? flash_host_pkg::CMD_PROG_SETUP : req_data_i;
         end else if (state == ST_WSETUP && data_lines_oe_o) begin
            // Second word changes a cycle after the strobe rose, never on that edge.
            data_lines_o <= second_data;
         end
      end
   end

   // ****************************************
   // User answers
   // ****************************************
   // Refusals in ST_IDLE answer at once; in ST_ASLEEP any request other than a wake gets no answer at all.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         req_ready_o   <= 1'b0;
         rsp_valid_o   <= 1'b0;
         rsp_refused_o <= 1'b0;
         rsp_data_o    <= '0;
      end else begin
         req_ready_o   <= 1'b0;
         rsp_valid_o   <= 1'b0;
         rsp_refused_o <= 1'b0;
         if (state == ST_IDLE && req_valid_i) begin
            if ((req_op_i == flash_host_pkg::OP_CMD && !cmd_defined(req_data_i)) ||
                ((req_op_i == flash_host_pkg::OP_ERASE ||
                  req_op_i == flash_host_pkg::OP_PROGRAM) &&
                 in_boot(req_addr_i) && !boot_unlock_i) ||
                req_op_i == flash_host_pkg::OP_WAKE || req_op_i > flash_host_pkg::OP_WAKE) begin
               rsp_valid_o   <= 1'b1;
               rsp_refused_o <= 1'b1;
            end
         end else if (state == ST_READ &&
                      count == flash_host_pkg::CNT_W'(flash_host_pkg::ACCESS_CYC + 3)) begin
            rsp_valid_o <= wake_read_ok;
            rsp_data_o  <= read_data;
         end else if (state == ST_WHOLD && !second_pending) begin
            rsp_valid_o <= 1'b1;
         end else if (state == ST_PDOWN &&
                      count == flash_host_pkg::CNT_W'(flash_host_pkg::RESET_PULSE_CYC - 1)) begin
            rsp_valid_o <= 1'b1;
         end else if (state == ST_WAKE &&
                      count == flash_host_pkg::CNT_W'(flash_host_pkg::WAKE_WRITE_CYC - 1)) begin
            rsp_valid_o <= 1'b1;
         end
         req_ready_o <= (state == ST_IDLE && !req_valid_i) || (state == ST_ASLEEP && !req_valid_i);
      end
   end

   // Boot blocks stay locked unless the user unlocks them.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         boot_lock_n_o <= 1'b0;
      end else begin
         boot_lock_n_o <= boot_unlock_i;
      end
   end
endmodule
`default_nettype wire

// ### rtl/flash_host_pkg.sv
// Constants shared by the host-side controller of a 16-bit boot-block flash.
// Assumes a 250 MHz core clock and a flash wired to the pins of flash_host_ctrl.
// Function
// - Host reads with select and gate low, strobe high, reset high.
// - Host holds reset low at least the minimum pulse width.
// - Host waits the wake-to-write delay before a new command.
// - Erase and program need a setup cycle then a confirm cycle; program here sends the data word as its second cycle.
// - Host never drives gate and strobe low together.
`default_nettype none
package flash_host_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_PS   = 4000;
   localparam int RESET_PULSE_NS  = 100;
   localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WAKE_OUT_NS     = 150;
   localparam int WAKE_OUT_CYC    = (WAKE_OUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WAKE_WRITE_NS   = 1000;
   localparam int WAKE_WRITE_CYC  = (WAKE_WRITE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ACCESS_NS       = 120;
   localparam int ACCESS_CYC      = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int STROBE_NS       = 60;
   localparam int STROBE_CYC      = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RECOVER_CYC     = 2;
   localparam int CNT_W           = 10;
   // ****************************************
   // Command codes and map
   // ****************************************
   localparam logic [15:0] CMD_READ_ARRAY   = 16'h00FF;
   localparam logic [15:0] CMD_READ_ID      = 16'h0090;
   localparam logic [15:0] CMD_READ_STATUS  = 16'h0070;
   localparam logic [15:0] CMD_CLEAR_STATUS = 16'h0050;
   localparam logic [15:0] CMD_ERASE_SETUP  = 16'h0020;
   localparam logic [15:0] CMD_CONFIRM      = 16'h00D0;
   localparam logic [15:0] CMD_PROG_SETUP   = 16'h0040;
   localparam logic [15:0] CMD_PROG_SETUP2  = 16'h0010;
   localparam logic [15:0] CMD_SUSPEND      = 16'h00B0;
   localparam logic [15:0] STATUS_READY     = 16'h0080;
   localparam logic [18:0] BOOT_BASE        = 19'h7E000;
   localparam logic [18:0] PARAM_BASE       = 19'h78000;
   localparam logic [2:0]  OP_READ          = 3'h0;
   localparam logic [2:0]  OP_CMD           = 3'h1;
   localparam logic [2:0]  OP_ERASE         = 3'h2;
   localparam logic [2:0]  OP_PROGRAM       = 3'h3;
   localparam logic [2:0]  OP_POWERDOWN     = 3'h4;
   localparam logic [2:0]  OP_WAKE          = 3'h5;
endpackage
`default_nettype wire

// ### rtl/flash_pin_sync.sv
// Three-stage synchroniser for pin inputs from the flash.
// Assumes the input is asynchronous to core_clk_i.
`default_nettype none
module flash_pin_sync #(
   parameter int WIDTH = 16
) (
   input  wire logic             core_clk_i,
   input  wire logic             resetn_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] stable_o
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // Stage one feeds only stage two; a change counts when two and three agree.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stage1   <= '0;
         stage2   <= '0;
         stage3   <= '0;
         stable_o <= '0;
      end else begin
         stage1 <= async_i;
         stage2 <= stage1;
         stage3 <= stage2;
         for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
               stable_o[i] <= stage3[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### sim/flash_host_sva.sv
// Checker for the pin and response timing of the flash host controller.
// Assumes it is bound to flash_host_ctrl and sees only that module's ports.
`default_nettype none
module flash_host_sva (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic boot_unlock_i,
   input wire logic rsp_valid_o,
   input wire logic rsp_refused_o,
   input wire logic chip_select_n_o,
   input wire logic output_gate_n_o,
   input wire logic write_strobe_n_o,
   input wire logic reset_powerdown_n_o,
   input wire logic boot_lock_n_o,
   input wire logic data_lines_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] lo_cnt;
   logic [9:0] hi_cnt;
   // Cycles spent low and high by the power-down pin; saturation keeps a wrap from passing.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lo_cnt <= 10'h000;
         hi_cnt <= 10'h000;
      end else begin
         lo_cnt <= reset_powerdown_n_o ? 10'h000 : lo_cnt + {9'h000, ~&lo_cnt};
         hi_cnt <= !reset_powerdown_n_o ? 10'h000 : hi_cnt + {9'h000, ~&hi_cnt};
      end
   end
   // ****
   // Properties
   // ****
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   gate_strobe_excl_a: assert property (output_gate_n_o || write_strobe_n_o)
      else $error("Gate and strobe low together.");
   read_pins_a: assert property (!output_gate_n_o |-> !chip_select_n_o && write_strobe_n_o
      && reset_powerdown_n_o) else $error("Read gate without proper select, strobe, reset.");
   drive_no_read_a: assert property (data_lines_oe_o |-> output_gate_n_o)
      else $error("Host drives data while the gate is low.");
   write_awake_a: assert property (!write_strobe_n_o |-> reset_powerdown_n_o
      && !chip_select_n_o && data_lines_oe_o) else $error("Strobe without wake, select, data.");
   strobe_width_a: assert property ($fell(write_strobe_n_o) |-> !write_strobe_n_o[*8])
      else $error("Write strobe too short.");
   strobe_first_a: assert property ($rose(write_strobe_n_o) |-> !chip_select_n_o)
      else $error("Select rose no later than strobe.");
   pd_width_a: assert property ($rose(reset_powerdown_n_o)
      |-> lo_cnt >= flash_host_pkg::RESET_PULSE_CYC) else $error("Power-down pulse too short.");
   wake_write_a: assert property ($fell(write_strobe_n_o)
      |-> hi_cnt >= flash_host_pkg::WAKE_WRITE_CYC) else $error("Write too soon after wake.");
   refuse_pulse_a: assert property (rsp_refused_o |-> rsp_valid_o ##1 !rsp_valid_o)
      else $error("Refusal is not a single response pulse.");
   lock_follow_a: assert property ($past(resetn_i) |-> boot_lock_n_o == $past(boot_unlock_i))
      else $error("Boot lock pin does not follow the unlock input.");
   pd_quiet_a: assert property (!reset_powerdown_n_o |-> chip_select_n_o && !data_lines_oe_o)
      else $error("Bus active during power-down.");
   read_c: cover property ($fell(output_gate_n_o));
   write_c: cover property ($fell(write_strobe_n_o));
   refuse_c: cover property (rsp_refused_o);
   wake_c: cover property ($rose(reset_powerdown_n_o));
endmodule
bind flash_host_ctrl flash_host_sva u_sva (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
   .boot_unlock_i(boot_unlock_i), .rsp_valid_o(rsp_valid_o), .rsp_refused_o(rsp_refused_o),
   .chip_select_n_o(chip_select_n_o), .output_gate_n_o(output_gate_n_o),
   .write_strobe_n_o(write_strobe_n_o), .reset_powerdown_n_o(reset_powerdown_n_o),
   .boot_lock_n_o(boot_lock_n_o), .data_lines_oe_o(data_lines_oe_o));
`default_nettype wire

// ### sim/flash_model.sv
// Behavioural boot-block flash answering the host controller's pins.
// Assumes operations finish at once; the program supply is a plain good or low level.
`default_nettype none
module flash_model #(
   parameter logic [15:0] MFR_CODE = 16'h00A5, // Arbitrary value.
   parameter logic [15:0] DEV_CODE = 16'h005A  // Arbitrary value.
) (
   input  wire logic        chip_select_n_i,
   input  wire logic        output_gate_n_i,
   input  wire logic        write_strobe_n_i,
   input  wire logic        reset_powerdown_n_i,
   input  wire logic        boot_lock_n_i,
   input  wire logic        vpp_ok_i,
   input  wire logic [18:0] addr_i,
   input  wire logic [15:0] host_data_i,
   input  wire logic        host_oe_i,
   output logic      [15:0] bus_o,
   output logic             drive_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [logic [18:0]];
   logic [1:0]  mode = 2'h0;
   logic        pend_erase = 1'b0;
   logic        pend_prog = 1'b0;
   logic        upd = 1'b0;
   logic [15:0] last = 16'h0000;
   logic [15:0] dout;
   function automatic logic [7:0] blk(input logic [18:0] a);
      return (a >= 19'h78000) ? {1'b1, a[18:12]} : {4'h0, a[18:15]};
   endfunction
   function automatic logic [15:0] rd(input logic [18:0] a);
      return mem.exists(a) ? mem[a] : 16'hFFFF;
   endfunction
   function automatic logic okw(input logic [18:0] a);
      return vpp_ok_i && !(a >= 19'h7E000 && !boot_lock_n_i);
   endfunction
   // Work is instant, so deselect never cuts an operation short and suspend has nothing to do.
   task automatic cmd(input logic [18:0] a, input logic [15:0] d);
      if (pend_prog) begin
         if (okw(a)) mem[a] = rd(a) & d;
         pend_prog = 1'b0;
         mode = 2'h2;
      end else if (pend_erase) begin
         if (d == 16'h00D0 && okw(a))
            foreach (mem[k]) if (blk(k) == blk(a)) mem[k] = 16'hFFFF;
         pend_erase = 1'b0;
         mode = 2'h2;
      end else begin
         case (d)
            16'h00FF: mode = 2'h0;
            16'h0090: mode = 2'h1;
            16'h0070: mode = 2'h2;
            16'h0020: pend_erase = 1'b1;
            16'h0040, 16'h0010: pend_prog = 1'b1;
            default: ;
         endcase
      end
      upd = ~upd;
   endtask
   // Capture on whichever of strobe or select rises first while awake.
   always @(posedge write_strobe_n_i or posedge chip_select_n_i) begin
      if (reset_powerdown_n_i && !(chip_select_n_i && write_strobe_n_i))
         cmd(addr_i, host_data_i);
   end
   // Power-down aborts pending work and wakes in array mode.
   always @(negedge reset_powerdown_n_i) begin
      mode = 2'h0;
      pend_erase = 1'b0;
      pend_prog = 1'b0;
   end
   // Read path; the supply level plays no part in it.
   always @(addr_i or mode or upd) begin
      dout = (mode == 2'h0) ? rd(addr_i) : (mode == 2'h1) ? (addr_i[0] ? DEV_CODE : MFR_CODE)
             : 16'h0080;
   end
   assign drive_o = !chip_select_n_i && !output_gate_n_i && write_strobe_n_i
                    && reset_powerdown_n_i;
   // A floating bus shows the inverse of the last data so stale values never pass.
   always @(negedge drive_o) last = dout;
   assign bus_o = drive_o ? dout : host_oe_i ? host_data_i : ~last;
endmodule
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the flash host controller against a behavioural flash.
// Assumes the controller answers each request with one response pulse.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [2:0] op; logic [18:0] addr; logic [15:0] data; logic un; logic vp;
      logic rf; logic chk; logic [15:0] rdata;
   } row_t;
   localparam row_t ROWS [20] = '{
      '{3'h0, 19'h00010, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b1, 16'hFFFF},
      '{3'h3, 19'h00010, 16'h1234, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000},
      '{3'h1, 19'h00000, 16'h00FF, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000},
      '{3'h0, 19'h00010, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b1, 16'h1234},
      '{3'h3, 19'h00020, 16'h5555, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000},
      '{3'h1, 19'h00000, 16'h00FF, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000},
      '{3'h0, 19'h00020, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b1, 16'hFFFF},
      '{3'h1, 19'h00000, 16'h0090, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000},
      '{3'h0, 19'h00000, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b1, 16'h00A5},
      '{3'h0, 19'h00001, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b1, 16'h005A},
      '{3'h1, 19'h00000, 16'h0070, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000},
      '{3'h0, 19'h00010, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b1, 16'h0080},
      '{3'h2, 19'h7F000, 16'h0000, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0000},
      '{3'h1, 19'h00000, 16'h0033, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0000},
      '{3'h6, 19'h00000, 16'h0000, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0000},
      '{3'h3, 19'h7F000, 16'h00AA, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0000},
      '{3'h2, 19'h00010, 16'h0000, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0000},
      '{3'h1, 19'h00000, 16'h00FF, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000},
      '{3'h0, 19'h7F000, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b1, 16'h00AA},
      '{3'h0, 19'h00010, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b1, 16'hFFFF}};
   logic core_clk_i = 1'b0, resetn_i = 1'b0, req_valid_i = 1'b0, boot_unlock_i = 1'b0;
   logic [2:0] req_op_i = 3'h0;
   logic [18:0] req_addr_i = 19'h00000;
   logic [15:0] req_data_i = 16'h0000, rsp_data_o, data_lines_o, bus, got;
   logic vpp_ok = 1'b1, req_ready_o, rsp_valid_o, rsp_refused_o, chip_select_n_o, rf;
   logic output_gate_n_o, write_strobe_n_o, reset_powerdown_n_o, boot_lock_n_o;
   logic data_lines_oe_o, fl_drive;
   logic [18:0] addr_o;
   int errors = 0, samples_checked = 0;
   always #2 core_clk_i = ~core_clk_i;
   flash_host_ctrl dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
      .req_op_i(req_op_i), .req_addr_i(req_addr_i), .req_data_i(req_data_i),
      .boot_unlock_i(boot_unlock_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
      .rsp_data_o(rsp_data_o), .rsp_refused_o(rsp_refused_o), .chip_select_n_o(chip_select_n_o),
      .output_gate_n_o(output_gate_n_o), .write_strobe_n_o(write_strobe_n_o),
      .reset_powerdown_n_o(reset_powerdown_n_o), .boot_lock_n_o(boot_lock_n_o),
      .addr_o(addr_o), .data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o),
      .data_lines_i(bus));
   flash_model fl (.chip_select_n_i(chip_select_n_o), .output_gate_n_i(output_gate_n_o),
      .write_strobe_n_i(write_strobe_n_o), .reset_powerdown_n_i(reset_powerdown_n_o),
      .boot_lock_n_i(boot_lock_n_o), .vpp_ok_i(vpp_ok), .addr_i(addr_o),
      .host_data_i(data_lines_o), .host_oe_i(data_lines_oe_o), .bus_o(bus), .drive_o(fl_drive));
   // ****
   // Tasks
   // ****
   task automatic final_report();
      $display("Checked %0d samples, %0d errors", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk_data(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      chk_data({15'h0000, g}, {15'h0000, e});
   endtask
   // Wait on the response pulse; the bound turns a hang into a counted mismatch.
   task automatic wait_rsp();
      int n;
      n = 0;
      while (rsp_valid_o !== 1'b1 && n < 2000) begin
         @(negedge core_clk_i);
         n++;
      end
      if (n >= 2000) chk_bit(1'b0, 1'b1);
   endtask
   task automatic do_req(input logic [2:0] op, input logic [18:0] a, input logic [15:0] d,
                         input logic un, input logic vp, output logic [15:0] g, output logic r);
      @(negedge core_clk_i);
      req_op_i = op;
      req_addr_i = a;
      req_data_i = d;
      boot_unlock_i = un;
      vpp_ok = vp;
      req_valid_i = 1'b1;
      @(negedge core_clk_i);
      wait_rsp();
      g = rsp_data_o;
      r = rsp_refused_o;
      req_valid_i = 1'b0;
      repeat (3) @(negedge core_clk_i);
   endtask
   // Watchdog sized well past the longest expected run.
   initial begin
      #240000;
      errors++;
      $display("Watchdog expired");
      final_report();
   end
   // ****
   // Main sequence
   // ****
   initial begin
      repeat (12) @(negedge core_clk_i);
      resetn_i = 1'b1;
      wait_rsp();
      chk_bit(req_ready_o, 1'b0);
      @(negedge core_clk_i);
      chk_bit(req_ready_o, 1'b1);
      foreach (ROWS[i]) begin
         do_req(ROWS[i].op, ROWS[i].addr, ROWS[i].data, ROWS[i].un, ROWS[i].vp, got, rf);
         chk_bit(rf, ROWS[i].rf);
         if (ROWS[i].chk) chk_data(got, ROWS[i].rdata);
         $display("Row %0d done", i);
      end
      do_req(3'h1, 19'h00000, 16'h0070, 1'b0, 1'b1, got, rf);
      do_req(flash_host_pkg::OP_POWERDOWN, 19'h00000, 16'h0000, 1'b0, 1'b1, got, rf);
      chk_bit(reset_powerdown_n_o, 1'b0);
      chk_bit(fl_drive, 1'b0);
      do_req(flash_host_pkg::OP_WAKE, 19'h00000, 16'h0000, 1'b0, 1'b1, got, rf);
      do_req(flash_host_pkg::OP_READ, 19'h7F000, 16'h0000, 1'b0, 1'b1, got, rf);
      chk_data(got, 16'h00AA);
      do_req(flash_host_pkg::OP_WAKE, 19'h00000, 16'h0000, 1'b0, 1'b1, got, rf);
      chk_bit(rf, 1'b1);
      $display("Power-down test done");
      // A reset in mid-strobe must abort the program and leave the bus idle.
      @(negedge core_clk_i);
      req_op_i = flash_host_pkg::OP_PROGRAM;
      req_addr_i = 19'h00030;
      req_data_i = 16'h0F0F;
      req_valid_i = 1'b1;
      repeat (8) @(negedge core_clk_i);
      resetn_i = 1'b0;
      req_valid_i = 1'b0;
      @(negedge core_clk_i);
      chk_bit(chip_select_n_o, 1'b1);
      chk_bit(reset_powerdown_n_o, 1'b0);
      chk_bit(data_lines_oe_o, 1'b0);
      repeat (11) @(negedge core_clk_i);
      resetn_i = 1'b1;
      wait_rsp();
      repeat (3) @(negedge core_clk_i);
      do_req(flash_host_pkg::OP_READ, 19'h00030, 16'h0000, 1'b0, 1'b1, got, rf);
      chk_data(got, 16'hFFFF);
      $display("Reset abort test done");
      final_report();
   end
endmodule
`default_nettype wire
